// ===== snd_pkg.sv
package snd_pkg;
	////////////////////////////////////////////////////////////
	// Word indices; byte address is four times the index
	localparam int IDX_W = 10;
	localparam logic [9:0] IDX_RUN_THR = 10'h03F;
	localparam logic [9:0] IDX_WAKE_THR = 10'h040;
	localparam logic [9:0] IDX_LOW_THR = 10'h041;
	localparam logic [9:0] IDX_SIG_CFG = 10'h043;
	localparam logic [9:0] IDX_ND_THR = 10'h044;
	localparam logic [9:0] IDX_ND_CFG = 10'h045;
	localparam logic [9:0] IDX_STATUS = 10'h050;
	localparam logic [9:0] IDX_MASK = 10'h051;
	localparam logic [9:0] IDX_POWER = 10'h052;
	localparam logic [9:0] IDX_PEAK = 10'h053;
	////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_THR = 8'h00;
	localparam logic [2:0] RST_SIG_CFG = 3'h0;
	localparam logic [7:0] RST_ND_THR = 8'h00;
	localparam logic [7:0] RST_ND_CFG = 8'h07;
	localparam logic [2:0] RST_STATUS = 3'h0;
	////////////////////////////////////////////////////////////
	// Field positions
	localparam int SC_RUN_CNT = 0;
	localparam int SC_WAKE_CNT = 1;
	localparam int SC_SRC = 2;
	localparam int ND_SLEW_LSB = 0;
	localparam int ND_LVL_LSB = 2;
	localparam int ND_MODE_LSB = 4;
	localparam int ND_RANGE_LSB = 6;
	localparam int ST_SD_RISE = 0;
	localparam int ST_SD_FALL = 1;
	localparam int ST_ND_RISE = 2;
	localparam int ST_W = 3;
	////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int BIT_RATE_BPS = 2400;
	localparam int HALF_BIT_NS = 500000000 / BIT_RATE_BPS;
	localparam int HALF_BIT_CYCLES = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		SND_MODE_SQUELCH,
		SND_MODE_NOISE,
		SND_MODE_BOTH,
		SND_MODE_GATED
	} snd_mode_t;
endpackage

// ===== snd_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface snd_cnt_if;
	logic enable;
	logic above;
	logic detect;
	modport ctl (output enable, output above, input detect);
	modport cnt (input enable, input above, output detect);
endinterface
`default_nettype wire

// ===== snd_thr_counter.sv
`timescale 1ns/1ps
`default_nettype none
module snd_thr_counter #(
	parameter int CYCLES = snd_pkg::HALF_BIT_CYCLES,
	parameter int CNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	snd_cnt_if.cnt cnt_bus
);
	localparam logic [CNT_W-1:0] LIM = CNT_W'(CYCLES - 1);
	logic [CNT_W-1:0] cnt_q;
	logic detect_q;

	// Any drop restarts the run
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (!cnt_bus.above) begin
			cnt_q <= '0;
		end else if (cnt_q != LIM) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			detect_q <= 1'b0;
		end else if (cnt_bus.enable) begin
			detect_q <= cnt_bus.above && (cnt_q == LIM);
		end else begin
			detect_q <= cnt_bus.above;
		end
	end

	assign cnt_bus.detect = detect_q;

	property p_cnt_restart;
		@(posedge ref_clk) disable iff (!nrst)
		!cnt_bus.above |=> cnt_q == '0;
	endproperty
	a_cnt_restart: assert property (p_cnt_restart) else $error("Count not restarted");

	property p_cnt_needs_run;
		@(posedge ref_clk) disable iff (!nrst)
		cnt_bus.enable && cnt_bus.above && cnt_q != LIM |=> !detect_q;
	endproperty
	a_cnt_needs_run: assert property (p_cnt_needs_run) else $error("Detect before half bit");
endmodule // snd_thr_counter
`default_nettype wire

// ===== snd_detector.sv
// Operation
// - Readout source: compared power or low-level value
// - Wakeup counter off, or half bit
// - Run counter off, or half bit
// - Writable 8-bit noise threshold, resets zero
// - Noise range scaling 2^7 down to 2^4
// - Mode 00: squelch only, reset default
// - Mode 01 noise only; 10 both
// - Mode 11: noise valid above low threshold
// - Noise level factor 1/2 to 1/8
// - Peak detector slew 1/256 to 1/32
// - Low threshold used only in mode 11
`timescale 1ns/1ps
`default_nettype none
module snd_detector #(
	parameter int HALF_BIT_CYCLES = snd_pkg::HALF_BIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sample_valid,
	input wire logic [7:0] signal_power,
	input wire logic [7:0] low_level_power,
	input wire logic [15:0] noise_level,
	input wire logic wakeup_mode,
	output logic sig_detect,
	output logic noise_detect,
	output logic rx_detect,
	output logic irq
);
	////////////////////////////////////////////////////////////
	function automatic logic [3:0] range_shift(input logic [1:0] sel);
		range_shift = 4'h7 - {2'h0, sel};
	endfunction

	function automatic logic [3:0] slew_shift(input logic [1:0] sel);
		slew_shift = 4'h8 - {2'h0, sel};
	endfunction

	function automatic logic [2:0] level_mult(input logic [1:0] sel);
		level_mult = 3'h4 - {1'b0, sel};
	endfunction

	////////////////////////////////////////////////////////////
	// Register file
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] run_thr_q;
	logic [7:0] wake_thr_q;
	logic [7:0] low_thr_q;
	logic [2:0] sig_cfg_q;
	logic [7:0] nd_thr_q;
	logic [7:0] nd_cfg_q;
	logic [2:0] status_q;
	logic [2:0] status_d;
	logic [2:0] mask_q;
	logic [7:0] power_q;
	logic [15:0] peak_q;
	logic [9:0] idx;
	logic req;
	logic wr;
	logic [7:0] wdat;

	assign idx = wb_adr_i[11:2];
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	// Only lane 0 carries data; upper lanes are ignored
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign wdat = wb_dat_i[7:0];

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			run_thr_q <= snd_pkg::RST_THR;
			wake_thr_q <= snd_pkg::RST_THR;
			low_thr_q <= snd_pkg::RST_THR;
			sig_cfg_q <= snd_pkg::RST_SIG_CFG;
			nd_thr_q <= snd_pkg::RST_ND_THR;
			nd_cfg_q <= snd_pkg::RST_ND_CFG;
			mask_q <= snd_pkg::RST_STATUS;
		end else if (wr) begin
			case (idx)
				snd_pkg::IDX_RUN_THR: run_thr_q <= wdat;
				snd_pkg::IDX_WAKE_THR: wake_thr_q <= wdat;
				snd_pkg::IDX_LOW_THR: low_thr_q <= wdat;
				snd_pkg::IDX_SIG_CFG: sig_cfg_q <= wdat[2:0];
				snd_pkg::IDX_ND_THR: nd_thr_q <= wdat;
				snd_pkg::IDX_ND_CFG: nd_cfg_q <= wdat;
				snd_pkg::IDX_MASK: mask_q <= wdat[2:0];
				default: ;
			endcase
		end
	end

	// Unmapped words read zero but still acknowledge
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			dat_q <= 32'h0000_0000;
		end else if (req) begin
			case (idx)
				snd_pkg::IDX_RUN_THR: dat_q <= {24'h00_0000, run_thr_q};
				snd_pkg::IDX_WAKE_THR: dat_q <= {24'h00_0000, wake_thr_q};
				snd_pkg::IDX_LOW_THR: dat_q <= {24'h00_0000, low_thr_q};
				snd_pkg::IDX_SIG_CFG: dat_q <= {29'h0000_0000, sig_cfg_q};
				snd_pkg::IDX_ND_THR: dat_q <= {24'h00_0000, nd_thr_q};
				snd_pkg::IDX_ND_CFG: dat_q <= {24'h00_0000, nd_cfg_q};
				snd_pkg::IDX_STATUS: dat_q <= {29'h0000_0000, status_q};
				snd_pkg::IDX_MASK: dat_q <= {29'h0000_0000, mask_q};
				snd_pkg::IDX_POWER: dat_q <= {24'h00_0000, power_q};
				snd_pkg::IDX_PEAK: dat_q <= {24'h00_0000, peak_q[15:8]};
				default: dat_q <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	////////////////////////////////////////////////////////////
	// Signal power readout
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			power_q <= 8'h00;
		end else if (sample_valid) begin
			power_q <= sig_cfg_q[snd_pkg::SC_SRC] ? low_level_power : signal_power;
		end
	end

	////////////////////////////////////////////////////////////
	// Signal detector with threshold counter
	snd_cnt_if cnt_bus ();
	logic above_q;
	logic [7:0] sig_thr;

	assign sig_thr = wakeup_mode ? wake_thr_q : run_thr_q;
	// Each mode has its own counter enable
	assign cnt_bus.enable = wakeup_mode ? sig_cfg_q[snd_pkg::SC_WAKE_CNT] : sig_cfg_q[snd_pkg::SC_RUN_CNT];
	assign cnt_bus.above = above_q;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			above_q <= 1'b0;
		end else if (sample_valid) begin
			above_q <= signal_power > sig_thr;
		end
	end

	snd_thr_counter #(
		.CYCLES(HALF_BIT_CYCLES),
		.CNT_W(32)
	) i_snd_thr_counter (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.cnt_bus(cnt_bus)
	);

	assign sig_detect = cnt_bus.detect;

	////////////////////////////////////////////////////////////
	// Noise detector
	logic [1:0] rsel;
	logic [1:0] lsel;
	logic [1:0] ssel;
	snd_pkg::snd_mode_t mode;
	logic [15:0] shifted;
	logic [7:0] scaled_q;
	logic [10:0] lvl_prod;
	logic [7:0] lvl;
	logic nd_raw_q;
	logic low_ok_q;
	logic nd_valid;
	logic nd_q;

	assign rsel = nd_cfg_q[snd_pkg::ND_RANGE_LSB +: 2];
	assign lsel = nd_cfg_q[snd_pkg::ND_LVL_LSB +: 2];
	assign ssel = nd_cfg_q[snd_pkg::ND_SLEW_LSB +: 2];
	assign mode = snd_pkg::snd_mode_t'(nd_cfg_q[snd_pkg::ND_MODE_LSB +: 2]);
	assign shifted = noise_level >> range_shift(rsel);
	assign lvl_prod = 11'(peak_q[15:8] * level_mult(lsel));
	assign lvl = lvl_prod[10:3];

	// Saturate rather than wrap on a coarse range
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			scaled_q <= 8'h00;
		end else if (sample_valid) begin
			scaled_q <= (shifted[15:8] != 8'h00) ? 8'hFF : shifted[7:0];
		end
	end

	// Instant attack, slow decay; eight fraction bits keep small steps
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			peak_q <= 16'h0000;
		end else if (scaled_q > peak_q[15:8]) begin
			peak_q <= {scaled_q, 8'h00};
		end else begin
			peak_q <= peak_q - (peak_q >> slew_shift(ssel));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			nd_raw_q <= 1'b0;
			low_ok_q <= 1'b0;
		end else begin
			nd_raw_q <= lvl < nd_thr_q;
			low_ok_q <= low_level_power > low_thr_q;
		end
	end

	// Low threshold ignored outside the gated mode
	assign nd_valid = (mode == snd_pkg::SND_MODE_GATED) ? (nd_raw_q && low_ok_q) : nd_raw_q;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			nd_q <= 1'b0;
		end else begin
			nd_q <= nd_valid;
		end
	end

	assign noise_detect = nd_q;

	////////////////////////////////////////////////////////////
	// Decision
	logic rx_q;
	logic rx_d;

	always_comb begin
		case (mode)
			snd_pkg::SND_MODE_SQUELCH: rx_d = cnt_bus.detect;
			snd_pkg::SND_MODE_NOISE: rx_d = nd_valid;
			snd_pkg::SND_MODE_BOTH: rx_d = cnt_bus.detect && nd_valid;
			snd_pkg::SND_MODE_GATED: rx_d = cnt_bus.detect && nd_valid;
			default: rx_d = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rx_q <= 1'b0;
		end else begin
			rx_q <= rx_d;
		end
	end

	assign rx_detect = rx_q;

	////////////////////////////////////////////////////////////
	// Events and interrupt; a set wins over a same-cycle clear
	logic [2:0] ev;
	logic [2:0] clr;
	logic irq_q;

	assign ev[snd_pkg::ST_SD_RISE] = rx_d && !rx_q;
	assign ev[snd_pkg::ST_SD_FALL] = !rx_d && rx_q;
	assign ev[snd_pkg::ST_ND_RISE] = nd_valid && !nd_q;
	assign clr = (wr && idx == snd_pkg::IDX_STATUS) ? wdat[2:0] : 3'h0;
	assign status_d = (status_q & ~clr) | ev;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			status_q <= snd_pkg::RST_STATUS;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_d & mask_q);
		end
	end

	assign irq = irq_q;

	////////////////////////////////////////////////////////////
	property p_src_low;
		@(posedge ref_clk) disable iff (!nrst)
		sample_valid && sig_cfg_q[snd_pkg::SC_SRC] |=> power_q == $past(low_level_power);
	endproperty
	a_src_low: assert property (p_src_low) else $error("Readout not low level");

	property p_wake_off;
		@(posedge ref_clk) disable iff (!nrst)
		wakeup_mode && !sig_cfg_q[snd_pkg::SC_WAKE_CNT] && above_q |=> sig_detect;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("Wakeup detect delayed");

	property p_run_off;
		@(posedge ref_clk) disable iff (!nrst)
		!wakeup_mode && !sig_cfg_q[snd_pkg::SC_RUN_CNT] && above_q |=> sig_detect;
	endproperty
	a_run_off: assert property (p_run_off) else $error("Run detect delayed");

	property p_nd_thr_wr;
		@(posedge ref_clk) disable iff (!nrst)
		wr && idx == snd_pkg::IDX_ND_THR |=> nd_thr_q == $past(wdat) && wb_ack_o;
	endproperty
	a_nd_thr_wr: assert property (p_nd_thr_wr) else $error("Noise threshold write lost");

	property p_range_min;
		@(posedge ref_clk) disable iff (!nrst)
		sample_valid && rsel == 2'h3 && noise_level[15:12] == 4'h0 |=> scaled_q == $past(noise_level[11:4]);
	endproperty
	a_range_min: assert property (p_range_min) else $error("Range scaling wrong");

	property p_squelch;
		@(posedge ref_clk) disable iff (!nrst)
		mode == snd_pkg::SND_MODE_SQUELCH |=> rx_detect == $past(sig_detect);
	endproperty
	a_squelch: assert property (p_squelch) else $error("Squelch mode wrong");

	property p_both;
		@(posedge ref_clk) disable iff (!nrst)
		mode == snd_pkg::SND_MODE_BOTH |=> rx_detect == $past(sig_detect && nd_raw_q);
	endproperty
	a_both: assert property (p_both) else $error("Combined mode wrong");

	property p_gated;
		@(posedge ref_clk) disable iff (!nrst)
		mode == snd_pkg::SND_MODE_GATED && !low_ok_q |=> !noise_detect && !rx_detect;
	endproperty
	a_gated: assert property (p_gated) else $error("Gate not applied");

	property p_low_ignored;
		@(posedge ref_clk) disable iff (!nrst)
		mode != snd_pkg::SND_MODE_GATED |=> noise_detect == $past(nd_raw_q);
	endproperty
	a_low_ignored: assert property (p_low_ignored) else $error("Low threshold leaked");

	property p_irq;
		@(posedge ref_clk) disable iff (!nrst)
		(status_q & mask_q) != 3'h0 && clr == 3'h0 |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt missing");

	c_gated_rx: cover property (@(posedge ref_clk) disable iff (!nrst) mode == snd_pkg::SND_MODE_GATED && $rose(rx_detect));
	c_cnt_det: cover property (@(posedge ref_clk) disable iff (!nrst) cnt_bus.enable && $rose(sig_detect));
	c_irq: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(irq));
endmodule // snd_detector
`default_nettype wire

// ===== snd_detector_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module snd_detector_tb;
	// Short half bit keeps the counter tests brief
	localparam int HB = 4;
	logic ref_clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack_o, sample_valid, wakeup_mode;
	logic sig_detect, noise_detect, rx_detect, irq;
	logic [11:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat, wb_dat_o, rd;
	logic [7:0] signal_power, low_level_power;
	logic [15:0] noise_level;
	int miscompares, cmp_count, cyc_cnt;
	////////////////////////////////////////////////////////////
	snd_detector #(.HALF_BIT_CYCLES(HB)) i_snd_detector (
		.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sample_valid(sample_valid), .signal_power(signal_power), .low_level_power(low_level_power),
		.noise_level(noise_level), .wakeup_mode(wakeup_mode), .sig_detect(sig_detect),
		.noise_detect(noise_detect), .rx_detect(rx_detect), .irq(irq)
	);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	// Master holds the request until the edge that samples ack
	task automatic xfer(input logic [9:0] idx, input logic we, input logic [7:0] wd, input logic [3:0] sel);
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_dat <= {24'h000000, wd};
		wb_sel <= sel;
		@(posedge ref_clk);
		// No local limit; only the bench timeout ends a hung wait
		while (wb_ack_o !== 1'b1) begin
			@(posedge ref_clk);
		end
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] v);
		xfer(idx, 1'b1, v, 4'hF);
	endtask
	task automatic rchk(input string nm, input logic [9:0] idx, input logic [7:0] e);
		xfer(idx, 1'b0, 8'h00, 4'hF);
		`CHK(nm, {24'h000000, e}, rd)
	endtask
	task automatic smp(input logic [7:0] p, input logic [7:0] lo, input logic [15:0] nz, input int n);
		@(posedge ref_clk);
		signal_power <= p;
		low_level_power <= lo;
		noise_level <= nz;
		sample_valid <= 1'b1;
		repeat (n) @(posedge ref_clk);
		sample_valid <= 1'b0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 12'h000;
		wb_sel = 4'h0;
		wb_dat = 32'h00000000;
		sample_valid = 1'b0;
		wakeup_mode = 1'b0;
		signal_power = 8'h00;
		low_level_power = 8'h00;
		noise_level = 16'h0000;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		rchk("nd_thr rst", snd_pkg::IDX_ND_THR, 8'h00);
		rchk("nd_cfg rst", snd_pkg::IDX_ND_CFG, 8'h07);
		rchk("sig_cfg rst", snd_pkg::IDX_SIG_CFG, 8'h00);
		rchk("unmapped", 10'h3FF, 8'h00);
		`CHK("rx rst", 1'b0, rx_detect)
		tend("reset");
		wr(snd_pkg::IDX_ND_THR, 8'hA5);
		rchk("nd_thr rw", snd_pkg::IDX_ND_THR, 8'hA5);
		xfer(snd_pkg::IDX_ND_THR, 1'b1, 8'h5A, 4'h0);
		rchk("nd_thr sel0", snd_pkg::IDX_ND_THR, 8'hA5);
		wr(snd_pkg::IDX_SIG_CFG, 8'hFF);
		rchk("sig_cfg rw", snd_pkg::IDX_SIG_CFG, 8'h07);
		for (int i = 3; i >= 0; i--) begin
			wr(snd_pkg::IDX_ND_CFG, 8'(8'h55 * i));
			rchk("nd_cfg rw", snd_pkg::IDX_ND_CFG, 8'(8'h55 * i));
		end
		tend("registers");
		// Noise threshold zero keeps the noise path quiet here
		wr(snd_pkg::IDX_ND_THR, 8'h00);
		wr(snd_pkg::IDX_SIG_CFG, 8'h00);
		wr(snd_pkg::IDX_ND_CFG, 8'h04);
		wr(snd_pkg::IDX_RUN_THR, 8'h40);
		wr(snd_pkg::IDX_WAKE_THR, 8'hC0);
		// Register tests left sticky events behind
		wr(snd_pkg::IDX_STATUS, 8'h07);
		rchk("status clr", snd_pkg::IDX_STATUS, 8'h00);
		wr(snd_pkg::IDX_MASK, 8'h07);
		smp(8'h20, 8'h00, 16'h0000, 1);
		wt(6);
		`CHK("sig low", 1'b0, sig_detect)
		smp(8'h80, 8'h00, 16'h0000, 1);
		wt(6);
		`CHK("sig run", 1'b1, sig_detect)
		`CHK("rx squelch", 1'b1, rx_detect)
		`CHK("irq set", 1'b1, irq)
		rchk("status rise", snd_pkg::IDX_STATUS, 8'h01);
		wr(snd_pkg::IDX_STATUS, 8'h01);
		wt(3);
		`CHK("irq clr", 1'b0, irq)
		wakeup_mode <= 1'b1;
		smp(8'h80, 8'h00, 16'h0000, 1);
		wt(6);
		`CHK("sig wake below", 1'b0, sig_detect)
		`CHK("irq fall", 1'b1, irq)
		smp(8'hD0, 8'h00, 16'h0000, 1);
		wt(6);
		`CHK("sig wake", 1'b1, sig_detect)
		tend("squelch");
		wr(snd_pkg::IDX_SIG_CFG, 8'h01);
		wakeup_mode <= 1'b0;
		smp(8'h20, 8'h00, 16'h0000, 1);
		wt(HB + 4);
		`CHK("sig cleared", 1'b0, sig_detect)
		smp(8'h80, 8'h00, 16'h0000, 1);
		wt(1);
		smp(8'h20, 8'h00, 16'h0000, 1);
		wt(HB + 4);
		`CHK("sig broken", 1'b0, sig_detect)
		smp(8'h80, 8'h00, 16'h0000, 1);
		wt(2);
		`CHK("sig early", 1'b0, sig_detect)
		wt(HB + 4);
		`CHK("sig counted", 1'b1, sig_detect)
		wr(snd_pkg::IDX_SIG_CFG, 8'h02);
		wakeup_mode <= 1'b1;
		smp(8'h20, 8'h00, 16'h0000, 1);
		smp(8'hD0, 8'h00, 16'h0000, 1);
		wt(2);
		`CHK("wake early", 1'b0, sig_detect)
		wt(HB + 4);
		`CHK("wake counted", 1'b1, sig_detect)
		tend("counters");
		wakeup_mode <= 1'b0;
		smp(8'h5A, 8'h33, 16'h0000, 1);
		rchk("power readout", snd_pkg::IDX_POWER, 8'h5A);
		wr(snd_pkg::IDX_SIG_CFG, 8'h04);
		smp(8'h5A, 8'h33, 16'h0000, 1);
		rchk("low readout", snd_pkg::IDX_POWER, 8'h33);
		tend("readout");
		wr(snd_pkg::IDX_ND_THR, 8'h10);
		wr(snd_pkg::IDX_LOW_THR, 8'h20);
		smp(8'h00, 8'h00, 16'h0000, 1);
		wt(8);
		`CHK("rx mode00 noise", 1'b0, rx_detect)
		wr(snd_pkg::IDX_STATUS, 8'h07);
		wr(snd_pkg::IDX_ND_CFG, 8'h14);
		wt(8);
		`CHK("nd mode01", 1'b1, noise_detect)
		`CHK("rx mode01", 1'b1, rx_detect)
		`CHK("irq noise", 1'b1, irq)
		wr(snd_pkg::IDX_ND_CFG, 8'h24);
		smp(8'h80, 8'h00, 16'h0000, 1);
		wt(8);
		`CHK("rx mode10", 1'b1, rx_detect)
		wr(snd_pkg::IDX_ND_CFG, 8'h34);
		wt(8);
		`CHK("nd gated", 1'b0, noise_detect)
		smp(8'h80, 8'h40, 16'h0000, 1);
		wt(8);
		`CHK("nd gate open", 1'b1, noise_detect)
		tend("modes");
		// Slow slew keeps the peak near its load, so range and level settle cleanly
		wr(snd_pkg::IDX_ND_CFG, 8'h14);
		smp(8'h00, 8'h00, 16'h0400, 1);
		wt(8);
		`CHK("range 00", 1'b1, noise_detect)
		wr(snd_pkg::IDX_ND_CFG, 8'hD4);
		smp(8'h00, 8'h00, 16'h0400, 1);
		wt(8);
		`CHK("range 11", 1'b0, noise_detect)
		wr(snd_pkg::IDX_ND_CFG, 8'hDC);
		wt(8);
		`CHK("level 11", 1'b1, noise_detect)
		wr(snd_pkg::IDX_ND_CFG, 8'hD0);
		wt(8);
		`CHK("level 00", 1'b0, noise_detect)
		smp(8'h00, 8'h00, 16'h0000, 40);
		`CHK("slew 00 hold", 1'b0, noise_detect)
		wr(snd_pkg::IDX_ND_CFG, 8'hD3);
		smp(8'h00, 8'h00, 16'h0000, 60);
		`CHK("slew 11 decay", 1'b1, noise_detect)
		tend("noise");
		give_verdict();
	end
endmodule // snd_detector_tb
`undef CHK
`default_nettype wire
